// File: core/fliv_pkg.sv
// Shared constants and types for the four-level vectored interrupt controller
`default_nettype none
package fliv_pkg;
  localparam int unsigned NUM_SRC = 10;
  localparam int unsigned CLKS_PER_MC = 4;
  localparam int unsigned LONG_CALL_MC = 4;
  // Source index in arbitration order, 0 ranks highest
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_BOD = 1;
  localparam int unsigned SRC_WDOG = 2;
  localparam int unsigned SRC_TMR0 = 3;
  localparam int unsigned SRC_CONV = 4;
  localparam int unsigned SRC_EXT1 = 5;
  localparam int unsigned SRC_EDGE = 6;
  localparam int unsigned SRC_TMR1 = 7;
  localparam int unsigned SRC_PWMU = 8;
  localparam int unsigned SRC_PWMB = 9;
  // Enable and priority bit positions
  localparam int unsigned BIT_EXT0 = 0;
  localparam int unsigned BIT_TMR0 = 1;
  localparam int unsigned BIT_EXT1 = 2;
  localparam int unsigned BIT_TMR1 = 3;
  localparam int unsigned BIT_BOD = 5;
  localparam int unsigned BIT_CONV = 6;
  localparam int unsigned BIT_GATE = 7;
  localparam int unsigned BIT_WDOG = 4;
  localparam int unsigned BIT_PWMB = 5;
  localparam int unsigned BIT_PWMU = 6;
  localparam int unsigned BIT_EDGE = 7;
  // Vectors
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TMR0 = 16'h000b;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TMR1 = 16'h001b;
  localparam logic [15:0] VEC_BOD = 16'h002b;
  localparam logic [15:0] VEC_EDGE = 16'h003b;
  localparam logic [15:0] VEC_WDOG = 16'h0053;
  localparam logic [15:0] VEC_CONV = 16'h005b;
  localparam logic [15:0] VEC_PWMU = 16'h006b;
  localparam logic [15:0] VEC_PWMB = 16'h0073;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] RST_INSVC = 4'h0;
  // Register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_MAIN_EN = 8'h00;
  localparam logic [7:0] ADDR_EXT_EN = 8'h04;
  localparam logic [7:0] ADDR_PRIO_LO_A = 8'h08;
  localparam logic [7:0] ADDR_PRIO_HI_A = 8'h0c;
  localparam logic [7:0] ADDR_PRIO_LO_B = 8'h10;
  localparam logic [7:0] ADDR_PRIO_HI_B = 8'h14;
  localparam logic [7:0] ADDR_EXT_MODE = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Long-call request to the core
  typedef struct packed {
    logic valid;
    logic [3:0] src;
    logic [15:0] vector;
    logic [1:0] level;
  } fliv_call_type;
  // Per-instruction status from the core sequencer
  typedef struct packed {
    logic last_mc;
    logic reg_write;
    logic return_from_interrupt;
    logic ret_plain;
  } fliv_instr_type;
  // Stored priority: high bit and low bit of each source
  typedef struct packed {
    logic [NUM_SRC-1:0] hi;
    logic [NUM_SRC-1:0] lo;
  } fliv_prio_type;
endpackage
`default_nettype wire

// File: core/fliv_arbiter.sv
// Level and rank arbitration among pending sources
`default_nettype none
module fliv_arbiter
  import fliv_pkg::*;
(
  input wire logic [fliv_pkg::NUM_SRC-1:0] pend,
  input wire fliv_pkg::fliv_prio_type prio,
  output logic found,
  output logic [3:0] win_src,
  output logic [1:0] win_lvl
);
  always_comb
  begin
    found = 1'b0;
    win_src = 4'h0;
    win_lvl = 2'b00;
    // Highest level first, then lowest index inside a level
    for (int l = 3; l >= 0; l--)
    begin
      for (int s = 0; s < NUM_SRC; s++)
      begin
        if (!found && pend[s] && ({prio.hi[s], prio.lo[s]} == l[1:0]))
        begin
          found = 1'b1;
          win_src = s[3:0];
          win_lvl = l[1:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: core/fliv_ctrl.sv
// Four-level vectored interrupt controller with AXI4-Lite register slave
// Overview of operation
// - No request memory; every poll is fresh
// - Timer overflow flags cleared on vectoring
// - External flags cleared only in edge mode
// - Watchdog and other soft flags left for software
// - Long-call pushes PC, loads winning vector
// - Fixed vector address per source
// - Return-from-interrupt ends current service routine
// - Plain return leaves in-service state alone
// - Two priority bits give four levels
// - Preempt only by strictly higher level
// - Highest level wins, then fixed rank
// - Enable bits in main/extended enable registers
// - Priority bits share the enable bit index
// - Only four sources may wake power-down
// - Sample at C3, poll next machine cycle
// - Long-call spans four machine cycles
// - Latency bounded by twelve machine cycles
// - Call only on clean last cycle
// - Global gate masks every source
// - Edge mode: high then low sets flag
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`default_nettype none
module fliv_ctrl
  import fliv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_input_0,
  input wire logic ext_input_1,
  input wire logic tmr0_ovf_set,
  input wire logic tmr1_ovf_set,
  input wire logic [7:0] src_flag_in,
  input wire fliv_pkg::fliv_instr_type instr,
  input wire logic conv_clk_rc,
  output fliv_pkg::fliv_call_type call,
  output logic mc_phase_c3,
  output logic wake_req,
  output logic ext0_req_flag,
  output logic ext1_req_flag,
  output logic tmr0_ovf_flag,
  output logic tmr1_ovf_flag
);
  // src_flag_in: software-cleared flags, one bit per source index 1,2,4,6, PWMU on bit 0, PWMB on bit 3
  // (index of fliv_pkg source numbering, bits 5,7 unused)

  // ----------------------------------------------------------------
  // Machine-cycle phase divider
  // ----------------------------------------------------------------
  logic [1:0] phase_r, phase_nxt;
  logic c3, c4;
  assign c3 = (phase_r == 2'd2);
  assign c4 = (phase_r == 2'd3);
  always_comb
  begin
    phase_nxt = phase_r + 2'd1;
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_s1_r, pin_s2_r, pin_smp_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_r <= 2'b11;
      pin_s2_r <= 2'b11;
    end
    else
    begin
      pin_s1_r <= {ext_input_1, ext_input_0};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] main_enable_reg_r, extended_enable_reg_r;
  logic [7:0] priority_low_bank_a_r, priority_high_bank_a_r;
  logic [7:0] priority_low_bank_b_r, priority_high_bank_b_r;
  logic [1:0] ext_mode_r;
  logic [7:0] main_en_nxt, ext_en_nxt, pla_nxt, pha_nxt, plb_nxt, phb_nxt;
  logic [1:0] ext_mode_nxt;

  // ----------------------------------------------------------------
  // Flags, in-service state and call sequencing
  // ----------------------------------------------------------------
  logic ext0_nxt, ext1_nxt, tmr0_nxt, tmr1_nxt;
  logic [3:0] insvc_r, insvc_nxt;
  logic [NUM_SRC-1:0] poll_r, poll_nxt;
  logic [1:0] pin_smp_nxt;
  fliv_call_type call_nxt;
  logic [1:0] call_cnt_r, call_cnt_nxt;
  logic wake_nxt;

  logic [NUM_SRC-1:0] en_vec, flag_vec;
  fliv_prio_type prio;
  logic found;
  logic [3:0] win_src;
  logic [1:0] win_lvl;

  function automatic logic [15:0] vec_of(input logic [3:0] s);
    unique case (s)
      4'd0: vec_of = VEC_EXT0;
      4'd1: vec_of = VEC_BOD;
      4'd2: vec_of = VEC_WDOG;
      4'd3: vec_of = VEC_TMR0;
      4'd4: vec_of = VEC_CONV;
      4'd5: vec_of = VEC_EXT1;
      4'd6: vec_of = VEC_EDGE;
      4'd7: vec_of = VEC_TMR1;
      4'd8: vec_of = VEC_PWMU;
      4'd9: vec_of = VEC_PWMB;
      default: vec_of = 16'h0000;
    endcase
  endfunction

  // Highest in-service level, or 4 (bit 2 set) when none
  function automatic logic [2:0] top_level(input logic [3:0] v);
    top_level = 3'b100;
    for (int i = 0; i < 4; i++)
    begin
      if (v[i])
      begin
        top_level = {1'b0, i[1:0]};
      end
    end
  endfunction

  always_comb
  begin
    en_vec = '0;
    en_vec[SRC_EXT0] = main_enable_reg_r[BIT_EXT0];
    en_vec[SRC_TMR0] = main_enable_reg_r[BIT_TMR0];
    en_vec[SRC_EXT1] = main_enable_reg_r[BIT_EXT1];
    en_vec[SRC_TMR1] = main_enable_reg_r[BIT_TMR1];
    en_vec[SRC_BOD] = main_enable_reg_r[BIT_BOD];
    en_vec[SRC_CONV] = main_enable_reg_r[BIT_CONV];
    en_vec[SRC_WDOG] = extended_enable_reg_r[BIT_WDOG];
    en_vec[SRC_PWMB] = extended_enable_reg_r[BIT_PWMB];
    en_vec[SRC_PWMU] = extended_enable_reg_r[BIT_PWMU];
    en_vec[SRC_EDGE] = extended_enable_reg_r[BIT_EDGE];
    // High and low bits form the level
    prio.lo = '0;
    prio.hi = '0;
    prio.lo[SRC_EXT0] = priority_low_bank_a_r[BIT_EXT0];
    prio.lo[SRC_TMR0] = priority_low_bank_a_r[BIT_TMR0];
    prio.lo[SRC_EXT1] = priority_low_bank_a_r[BIT_EXT1];
    prio.lo[SRC_TMR1] = priority_low_bank_a_r[BIT_TMR1];
    prio.lo[SRC_BOD] = priority_low_bank_a_r[BIT_BOD];
    prio.lo[SRC_CONV] = priority_low_bank_a_r[BIT_CONV];
    prio.lo[SRC_WDOG] = priority_low_bank_b_r[BIT_WDOG];
    prio.lo[SRC_PWMB] = priority_low_bank_b_r[BIT_PWMB];
    prio.lo[SRC_PWMU] = priority_low_bank_b_r[BIT_PWMU];
    prio.lo[SRC_EDGE] = priority_low_bank_b_r[BIT_EDGE];
    prio.hi[SRC_EXT0] = priority_high_bank_a_r[BIT_EXT0];
    prio.hi[SRC_TMR0] = priority_high_bank_a_r[BIT_TMR0];
    prio.hi[SRC_EXT1] = priority_high_bank_a_r[BIT_EXT1];
    prio.hi[SRC_TMR1] = priority_high_bank_a_r[BIT_TMR1];
    prio.hi[SRC_BOD] = priority_high_bank_a_r[BIT_BOD];
    prio.hi[SRC_CONV] = priority_high_bank_a_r[BIT_CONV];
    prio.hi[SRC_WDOG] = priority_high_bank_b_r[BIT_WDOG];
    prio.hi[SRC_PWMB] = priority_high_bank_b_r[BIT_PWMB];
    prio.hi[SRC_PWMU] = priority_high_bank_b_r[BIT_PWMU];
    prio.hi[SRC_EDGE] = priority_high_bank_b_r[BIT_EDGE];
    flag_vec = '0;
    flag_vec[SRC_EXT0] = ext0_req_flag;
    flag_vec[SRC_EXT1] = ext1_req_flag;
    flag_vec[SRC_TMR0] = tmr0_ovf_flag;
    flag_vec[SRC_TMR1] = tmr1_ovf_flag;
    flag_vec[SRC_BOD] = src_flag_in[SRC_BOD];
    flag_vec[SRC_WDOG] = src_flag_in[SRC_WDOG];
    flag_vec[SRC_CONV] = src_flag_in[SRC_CONV];
    flag_vec[SRC_EDGE] = src_flag_in[SRC_EDGE];
    flag_vec[8] = 1'b0;
    flag_vec[9] = 1'b0;
  end

  // PWM flags sit above the 8-bit input; reuse unused slots 0 and 3
  logic [NUM_SRC-1:0] flags_all;
  always_comb
  begin
    flags_all = flag_vec;
    flags_all[SRC_PWMU] = src_flag_in[0];
    flags_all[SRC_PWMB] = src_flag_in[3];
  end

  logic [NUM_SRC-1:0] pend;
  fliv_arbiter u_arb (
    .pend(pend),
    .prio(prio),
    .found(found),
    .win_src(win_src),
    .win_lvl(win_lvl)
  );

  logic can_call;
  logic [2:0] top_lvl;
  always_comb
  begin
    // Poll uses the snapshot of this cycle only
    pend = poll_r & en_vec & {NUM_SRC{main_enable_reg_r[BIT_GATE]}};
    top_lvl = top_level(insvc_r);
    // Strictly higher than any routine in service
    // Last cycle, no register write, no return
    can_call = found && c4 && (call_cnt_r == 2'd0) && instr.last_mc
      && !instr.reg_write && !instr.return_from_interrupt
      && (top_lvl[2] || ({1'b0, win_lvl} > top_lvl));
  end

  always_comb
  begin
    pin_smp_nxt = pin_smp_r;
    ext0_nxt = ext0_req_flag;
    ext1_nxt = ext1_req_flag;
    tmr0_nxt = tmr0_ovf_flag | tmr0_ovf_set;
    tmr1_nxt = tmr1_ovf_flag | tmr1_ovf_set;
    poll_nxt = poll_r;
    insvc_nxt = insvc_r;
    call_nxt = call;
    call_cnt_nxt = call_cnt_r;
    // Pins sampled and external flags updated at C3
    if (c3)
    begin
      pin_smp_nxt = pin_s2_r;
      ext0_nxt = ext_mode_r[0] ? (ext0_req_flag | (pin_smp_r[0] & ~pin_s2_r[0]))
        : ~pin_s2_r[0];
      ext1_nxt = ext_mode_r[1] ? (ext1_req_flag | (pin_smp_r[1] & ~pin_s2_r[1]))
        : ~pin_s2_r[1];
    end
    // Snapshot at cycle start is polled at C4 of the same machine cycle
    if (phase_r == 2'd0)
    begin
      poll_nxt = flags_all;
    end
    if (c4 && call_cnt_r != 2'd0)
    begin
      call_cnt_nxt = call_cnt_r - 2'd1;
    end
    call_nxt.valid = 1'b0;
    if (can_call)
    begin
      call_nxt.valid = 1'b1;
      call_nxt.src = win_src;
      call_nxt.level = win_lvl;
      call_nxt.vector = vec_of(win_src);
      call_cnt_nxt = 2'(LONG_CALL_MC - 1);
      insvc_nxt[win_lvl] = 1'b1;
      // Timer flags cleared; event in same cycle still wins
      if (win_src == 4'(SRC_TMR0))
      begin
        tmr0_nxt = tmr0_ovf_set;
      end
      if (win_src == 4'(SRC_TMR1))
      begin
        tmr1_nxt = tmr1_ovf_set;
      end
      // External flags cleared only in edge mode
      if (win_src == 4'(SRC_EXT0) && ext_mode_r[0])
      begin
        ext0_nxt = 1'b0;
      end
      if (win_src == 4'(SRC_EXT1) && ext_mode_r[1])
      begin
        ext1_nxt = 1'b0;
      end
      // Watchdog and other soft flags are untouched here
    end
    // Return ends highest level; plain return ignored
    if (c4 && instr.last_mc && instr.return_from_interrupt && !top_lvl[2])
    begin
      insvc_nxt[top_lvl[1:0]] = 1'b0;
    end
  end

  // Wake sources: ext0, ext1, brownout, ADC on RC clock
  always_comb
  begin
    wake_nxt = main_enable_reg_r[BIT_GATE] & (
      (ext0_req_flag & en_vec[SRC_EXT0]) | (ext1_req_flag & en_vec[SRC_EXT1])
      | (flags_all[SRC_BOD] & en_vec[SRC_BOD])
      | (flags_all[SRC_CONV] & en_vec[SRC_CONV] & conv_clk_rc));
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt, w_data_r, w_data_nxt;
  logic w_lane_r, w_lane_nxt;
  logic bvalid_nxt, rvalid_nxt, awready_nxt, wready_nxt, arready_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_lane_nxt = w_lane_r;
    bvalid_nxt = s_axi_bvalid & ~s_axi_bready;
    bresp_nxt = s_axi_bresp;
    rvalid_nxt = s_axi_rvalid & ~s_axi_rready;
    rresp_nxt = s_axi_rresp;
    rdata_nxt = s_axi_rdata;
    main_en_nxt = main_enable_reg_r;
    ext_en_nxt = extended_enable_reg_r;
    pla_nxt = priority_low_bank_a_r;
    pha_nxt = priority_high_bank_a_r;
    plb_nxt = priority_low_bank_b_r;
    phb_nxt = priority_high_bank_b_r;
    ext_mode_nxt = ext_mode_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    if (aw_hold_r && w_hold_r && !s_axi_bvalid)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (aw_addr_r)
        ADDR_MAIN_EN: if (w_lane_r) main_en_nxt = w_data_r;
        ADDR_EXT_EN: if (w_lane_r) ext_en_nxt = w_data_r;
        ADDR_PRIO_LO_A: if (w_lane_r) pla_nxt = w_data_r;
        ADDR_PRIO_HI_A: if (w_lane_r) pha_nxt = w_data_r;
        ADDR_PRIO_LO_B: if (w_lane_r) plb_nxt = w_data_r;
        ADDR_PRIO_HI_B: if (w_lane_r) phb_nxt = w_data_r;
        ADDR_EXT_MODE: if (w_lane_r) ext_mode_nxt = w_data_r[1:0];
        ADDR_STATUS: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_hold_nxt && !(s_axi_awvalid && s_axi_awready);
    wready_nxt = !w_hold_nxt && !(s_axi_wvalid && s_axi_wready);
    arready_nxt = !rvalid_nxt && !(s_axi_arvalid && s_axi_arready);
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (s_axi_araddr[7:0])
        ADDR_MAIN_EN: rdata_nxt[7:0] = main_enable_reg_r;
        ADDR_EXT_EN: rdata_nxt[7:0] = extended_enable_reg_r;
        ADDR_PRIO_LO_A: rdata_nxt[7:0] = priority_low_bank_a_r;
        ADDR_PRIO_HI_A: rdata_nxt[7:0] = priority_high_bank_a_r;
        ADDR_PRIO_LO_B: rdata_nxt[7:0] = priority_low_bank_b_r;
        ADDR_PRIO_HI_B: rdata_nxt[7:0] = priority_high_bank_b_r;
        ADDR_EXT_MODE: rdata_nxt[1:0] = ext_mode_r;
        ADDR_STATUS: rdata_nxt[7:0] = {tmr1_ovf_flag, tmr0_ovf_flag, ext1_req_flag,
          ext0_req_flag, insvc_r};
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_r <= 2'd0;
      pin_smp_r <= 2'b11;
      ext0_req_flag <= 1'b0;
      ext1_req_flag <= 1'b0;
      tmr0_ovf_flag <= 1'b0;
      tmr1_ovf_flag <= 1'b0;
      poll_r <= '0;
      insvc_r <= RST_INSVC;
      call <= '0;
      call_cnt_r <= 2'd0;
      mc_phase_c3 <= 1'b0;
      wake_req <= 1'b0;
      main_enable_reg_r <= RST_REG;
      extended_enable_reg_r <= RST_REG;
      priority_low_bank_a_r <= RST_REG;
      priority_high_bank_a_r <= RST_REG;
      priority_low_bank_b_r <= RST_REG;
      priority_high_bank_b_r <= RST_REG;
      ext_mode_r <= 2'b00;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      phase_r <= phase_nxt;
      pin_smp_r <= pin_smp_nxt;
      ext0_req_flag <= ext0_nxt;
      ext1_req_flag <= ext1_nxt;
      tmr0_ovf_flag <= tmr0_nxt;
      tmr1_ovf_flag <= tmr1_nxt;
      poll_r <= poll_nxt;
      insvc_r <= insvc_nxt;
      call <= call_nxt;
      call_cnt_r <= call_cnt_nxt;
      mc_phase_c3 <= (phase_nxt == 2'd2);
      wake_req <= wake_nxt;
      main_enable_reg_r <= main_en_nxt;
      extended_enable_reg_r <= ext_en_nxt;
      priority_low_bank_a_r <= pla_nxt;
      priority_high_bank_a_r <= pha_nxt;
      priority_low_bank_b_r <= plb_nxt;
      priority_high_bank_b_r <= phb_nxt;
      ext_mode_r <= ext_mode_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_lane_r <= w_lane_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready <= wready_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp <= rresp_nxt;
      s_axi_rdata <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

// File: verif/fliv_monitor.sv
// Port-level assertions for the vectored interrupt controller
`default_nettype none
module fliv_monitor
  import fliv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic tmr0_ovf_set,
  input wire logic tmr0_ovf_flag,
  input wire fliv_pkg::fliv_instr_type instr,
  input wire fliv_pkg::fliv_call_type call,
  input wire logic mc_phase_c3
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  call_gap_a: assert property (call.valid |=> !call.valid [*8])
    else $error("second call inside long-call");
  call_phase_a: assert property (call.valid |-> $past(mc_phase_c3, 2))
    else $error("call off the machine-cycle slot");
  call_cause_a: assert property (call.valid |-> $past(instr.last_mc)
    && !$past(instr.reg_write) && !$past(instr.return_from_interrupt)) else $error("call on a blocked instruction");
  c3_period_a: assert property (mc_phase_c3 |=> !mc_phase_c3 [*3] ##1 mc_phase_c3)
    else $error("phase marker not every four clocks");
  tmr_clear_a: assert property (call.valid && call.src == 4'd3 && !$past(tmr0_ovf_set)
    |-> !tmr0_ovf_flag) else $error("timer flag kept on vectoring");
  call_keep_a: assert property (!call.valid |-> $stable(call.vector))
    else $error("vector moved between calls");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  cover property (call.valid && call.level == 2'd3);
  cover property (instr.return_from_interrupt);
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind fliv_ctrl fliv_monitor mon_u (.*);
`default_nettype wire

// File: verif/fliv_cpu_model.sv
// Core sequencer model: instruction status in the C4 slot
`default_nettype none
module fliv_cpu_model
  import fliv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic mc_phase_c3,
  input wire logic [1:0] op,
  input wire logic stall,
  output fliv_pkg::fliv_instr_type instr
);
  timeunit 1ns;
  timeprecision 1ps;
  fliv_instr_type instr_nxt;
  always_comb
  begin
    instr_nxt = '0;
    if (mc_phase_c3)
      instr_nxt = '{!stall, op == 2'd1, op == 2'd2, op == 2'd3};
  end
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      instr <= '0;
    else
      instr <= instr_nxt;
endmodule
`default_nettype wire

// File: verif/fliv_ctrl_test.sv
// Self-checking bench for the vectored interrupt controller
`default_nettype none
module fliv_ctrl_test;
  import fliv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int s; logic [7:0] m; logic [7:0] x; logic [15:0] v;} fliv_row_type;
  logic ref_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, stall;
  logic ext_input_0, ext_input_1, tmr0_ovf_set, tmr1_ovf_set, conv_clk_rc, mc_phase_c3, wake_req;
  logic ext0_req_flag, ext1_req_flag, tmr0_ovf_flag, tmr1_ovf_flag;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, op, rd_r, wr_r;
  logic [7:0] src_flag_in;
  fliv_instr_type instr;
  fliv_call_type call;
  int failures = 0;
  int n_tests = 0;
  fliv_row_type rows[10] = '{'{0, 8'h81, 8'h00, 16'h0003}, '{3, 8'h82, 8'h00, 16'h000b},
    '{5, 8'h84, 8'h00, 16'h0013}, '{7, 8'h88, 8'h00, 16'h001b}, '{1, 8'ha0, 8'h00, 16'h002b},
    '{4, 8'hc0, 8'h00, 16'h005b}, '{2, 8'h80, 8'h10, 16'h0053}, '{9, 8'h80, 8'h20, 16'h0073},
    '{8, 8'h80, 8'h40, 16'h006b}, '{6, 8'h80, 8'h80, 16'h003b}};
  fliv_ctrl dut_u (.*);
  fliv_cpu_model cpu_u (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    wr_r = s_axi_bresp;
  endtask
  // Answer is held back one cycle on purpose so the slave must keep it
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge ref_clk);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic op_do(input logic [1:0] k);
    @(posedge ref_clk iff mc_phase_c3);
    op <= k;
    @(posedge ref_clk iff mc_phase_c3);
    op <= 2'd0;
  endtask
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      chk("no call", 32'h0, {31'h0, call.valid});
    end
  endtask
  task automatic xcall(input logic [15:0] v);
    int i;
    for (i = 0; i < 80 && call.valid !== 1'b1; i++)
      @(posedge ref_clk);
    chk("vector", {15'h0, 1'b1, v}, {15'h0, call.valid, call.vector});
    chk("latency", 32'h1, {31'h0, i <= 48});
  endtask
  task automatic raise(input int s, input logic v);
    case (s)
      SRC_EXT0: ext_input_0 <= !v;
      SRC_EXT1: ext_input_1 <= !v;
      SRC_TMR0: tmr0_ovf_set <= v;
      SRC_TMR1: tmr1_ovf_set <= v;
      SRC_BOD: src_flag_in[1] <= v;
      SRC_WDOG: src_flag_in[2] <= v;
      SRC_CONV: src_flag_in[4] <= v;
      SRC_EDGE: src_flag_in[6] <= v;
      SRC_PWMU: src_flag_in[0] <= v;
      default: src_flag_in[3] <= v;
    endcase
  endtask
  task automatic kick(input int s);
    raise(s, 1'b1);
    @(posedge ref_clk);
    tmr0_ovf_set <= 1'b0;
    tmr1_ovf_set <= 1'b0;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end
  initial
  begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, src_flag_in, op, stall} = '0;
    {tmr0_ovf_set, tmr1_ovf_set, conv_clk_rc} = '0;
    {ext_input_0, ext_input_1} = 2'b11;
    s_axi_wstrb = 4'h1;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    wr(ADDR_EXT_MODE, 8'h03);
    foreach (rows[k])
    begin
      wr(ADDR_MAIN_EN, rows[k].m);
      wr(ADDR_EXT_EN, rows[k].x);
      kick(rows[k].s);
      xcall(rows[k].v);
      repeat (2) @(posedge ref_clk);
      chk("flags", 32'h0, {28'h0, ext0_req_flag, ext1_req_flag, tmr0_ovf_flag, tmr1_ovf_flag});
      raise(rows[k].s, 1'b0);
      op_do(2'd2);
    end
    wr(ADDR_PRIO_HI_A, 8'h08);
    wr(ADDR_PRIO_LO_A, 8'h08);
    wr(ADDR_MAIN_EN, 8'h89);
    stall <= 1'b1;
    raise(SRC_EXT0, 1'b1);
    kick(SRC_TMR1);
    repeat (16) @(posedge ref_clk);
    stall <= 1'b0;
    xcall(16'h001b);
    quiet(40);
    op_do(2'd3);
    rd(ADDR_STATUS);
    chk("status", 32'h18, rd_d);
    op_do(2'd2);
    xcall(16'h0003);
    raise(SRC_EXT0, 1'b0);
    op_do(2'd2);
    wr(ADDR_EXT_MODE, 8'h01);
    wr(ADDR_MAIN_EN, 8'h04);
    raise(SRC_EXT1, 1'b1);
    quiet(24);
    stall <= 1'b1;
    wr(ADDR_MAIN_EN, 8'h84);
    quiet(24);
    op <= 2'd1;
    stall <= 1'b0;
    quiet(12);
    stall <= 1'b1;
    op <= 2'd0;
    raise(SRC_EXT1, 1'b0);
    repeat (12) @(posedge ref_clk);
    stall <= 1'b0;
    quiet(24);
    raise(SRC_EXT1, 1'b1);
    xcall(16'h0013);
    chk("level", 32'h1, {31'h0, ext1_req_flag});
    raise(SRC_EXT1, 1'b0);
    stall <= 1'b1;
    op_do(2'd2);
    wr(ADDR_MAIN_EN, 8'hc0);
    raise(SRC_CONV, 1'b1);
    repeat (8) @(posedge ref_clk);
    chk("wake", 32'h0, {31'h0, wake_req});
    conv_clk_rc <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("wake", 32'h1, {31'h0, wake_req});
    rd(8'h20);
    chk("unmapped", 32'h2, {30'h0, rd_r});
    wr(8'h20, 8'h00);
    chk("wresp", 32'h2, {30'h0, wr_r});
    raise(SRC_CONV, 1'b0);
    stall <= 1'b0;
    wr(ADDR_PRIO_HI_B, 8'h10);
    wr(ADDR_EXT_EN, 8'h10);
    raise(SRC_WDOG, 1'b1);
    xcall(16'h0053);
    chk("prio_level", 32'h2, {30'h0, call.level});
    chk("source", SRC_WDOG, {28'h0, call.src});
    tally_and_finish();
  end
endmodule
`default_nettype wire
